// ### verilog/sfp_pkg.sv
/*
 * Shared constants and types for the serial flash port: command codes,
 * status byte layout, counts and the host clock divider.
 * Assumes both ends run on the same 125 MHz system clock.
 */
package sfp_pkg;
    // Command codes
    localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0B;
    localparam logic [7:0] DUAL_READ_CMD = 8'h3B;
    localparam logic [7:0] QUAD_READ_CMD = 8'h6B;
    localparam logic [7:0] PAGE_PROG_CMD = 8'h02;
    localparam logic [7:0] ERASE_4K_CMD = 8'h20;
    localparam logic [7:0] ERASE_32K_CMD = 8'h52;
    localparam logic [7:0] ERASE_64K_CMD = 8'hD8;
    // Status byte layout
    localparam int SR_LOCK = 7;
    localparam int SR_QE = 6;
    localparam int SR_BP_HI = 5;
    localparam int SR_BP_LO = 2;
    // Counts
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [3:0] DUMMY_LAST = 4'h7;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [8:0] BLOCK_COUNT = 9'h100;
    localparam logic [3:0] PROTECT_ALL = 4'h9;
    localparam logic [23:0] SECTOR_MASK = 24'hFFF000;
    localparam logic [23:0] BLOCK32_MASK = 24'hFF8000;
    localparam logic [23:0] BLOCK64_MASK = 24'hFF0000;
    // Host serial clock half period, a least time
    localparam int SCK_HALF_NS = 64;
    localparam int SYS_CLK_MHZ = 125;
    localparam logic [3:0] HALF_LAST = 4'((SCK_HALF_NS * SYS_CLK_MHZ + 999) / 1000 - 1);

    typedef enum logic [1:0] {LANE1 = 2'h0, LANE2 = 2'h1, LANE4 = 2'h2} sfp_lanes_type;
    typedef enum logic [1:0] {ER_4K = 2'h0, ER_32K = 2'h1, ER_64K = 2'h2} sfp_erase_type;

    // Clock edges per byte, less one, for a lane width
    function automatic logic [2:0] lane_last(input sfp_lanes_type ln);
        case (ln)
            LANE2: lane_last = 3'h3;
            LANE4: lane_last = 3'h1;
            default: lane_last = 3'h7;
        endcase
    endfunction
endpackage

// ### verilog/sfp_if.sv
/*
 * Pin bundle between the flash host and the flash device.
 * Assumes pulled-up data lines: an undriven line reads high.
 */
`timescale 1ns/1ps
interface sfp_if;
    logic cs_n;
    logic sck;
    logic [3:0] h_io_o;
    logic [3:0] h_io_oe;
    logic [3:0] d_io_o;
    logic [3:0] d_io_oe;
    logic [3:0] io;

    // Host drive wins over device drive; weak pull-up otherwise
    assign io = (h_io_oe & h_io_o) | (~h_io_oe & d_io_oe & d_io_o) | (~h_io_oe & ~d_io_oe);

    modport dev(input cs_n, input sck, input io, output d_io_o, output d_io_oe);
    modport host(output cs_n, output sck, output h_io_o, output h_io_oe, input io);
endinterface

// ### verilog/sfp_sync.sv
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are levels from outside the system clock domain.
 */
`timescale 1ns/1ps
module sfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sfp_sync_type;

    sfp_sync_type r;
    sfp_sync_type next_r;

    always_comb begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            r <= {INIT, INIT};
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.s2;
endmodule

// ### verilog/sfp_host.sv
/*
 * Host end of the serial flash port: runs one command frame per request,
 * making the serial clock by dividing the system clock.
 * Assumes the user issues the unlock command before writes.
 */
`timescale 1ns/1ps
module sfp_host (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Pins
    sfp_if.host bus,
    // Request
    input wire logic req_valid_i,
    input wire logic [7:0] req_cmd_i,
    input wire logic [23:0] req_addr_i,
    input wire logic req_addr_en_i,
    input wire logic [3:0] req_dummy_i,
    input wire logic [8:0] req_wlen_i,
    input wire logic [8:0] req_rlen_i,
    input wire sfp_pkg::sfp_lanes_type req_lanes_i,
    input wire logic mode3_i,
    output logic busy_o,
    // Write data stream
    input wire logic [7:0] wdata_i,
    output logic wdata_take_o,
    // Read data stream
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    // Pin levels
    input wire logic wp_n_i,
    input wire logic pause_i
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_TX = 3'h1, H_DUMMY = 3'h2, H_RX = 3'h3, H_END = 3'h4
    } sfp_hstate_type;

    typedef struct packed {
        sfp_hstate_type st;
        logic [3:0] div;
        logic cs_n;
        logic sck;
        logic hold_n;
        logic [7:0] sh;
        logic [2:0] bc;
        logic [1:0] hb;
        logic [23:0] addr;
        logic [8:0] wl;
        logic [8:0] rl;
        logic [3:0] dm;
        sfp_pkg::sfp_lanes_type ln;
        logic m3;
        logic [3:0] io_o;
        logic [3:0] io_oe;
        logic busy;
        logic take;
        logic rv;
        logic [7:0] rdat;
    } sfp_host_type;

    sfp_host_type r;
    sfp_host_type n;
    logic [3:0] io_s;
    logic p;
    logic tick;
    logic fin;
    logic [7:0] rs;

    sfp_sync #(.W(4), .INIT(4'hF)) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(bus.io),
        .q_o(io_s)
    );

    always_comb begin
        n = r;
        fin = 1'b0;
        n.take = 1'b0;
        n.rv = 1'b0;
        // Pause only in the low half so no edge is hidden behind it
        p = pause_i && r.st != H_IDLE && !r.sck && r.ln != sfp_pkg::LANE4;
        n.hold_n = !p;
        tick = r.div == sfp_pkg::HALF_LAST && !p && r.hold_n;
        case (r.ln)
            sfp_pkg::LANE2: rs = {r.sh[5:0], io_s[1:0]};
            sfp_pkg::LANE4: rs = {r.sh[3:0], io_s};
            default: rs = {r.sh[6:0], io_s[1]};
        endcase
        if (r.st == H_IDLE) begin
            n.sck = mode3_i;
            n.div = 4'h0;
            if (req_valid_i) begin
                n.st = H_TX;
                n.busy = 1'b1;
                n.cs_n = 1'b0;
                n.sck = 1'b0;
                n.m3 = mode3_i;
                n.sh = req_cmd_i;
                n.bc = sfp_pkg::BIT_LAST;
                n.hb = req_addr_en_i ? sfp_pkg::ADDR_BYTES : 2'h0;
                n.addr = req_addr_i;
                n.wl = (req_wlen_i > sfp_pkg::PAGE_BYTES) ? sfp_pkg::PAGE_BYTES : req_wlen_i;
                n.rl = req_rlen_i;
                n.dm = req_dummy_i;
                n.ln = req_lanes_i;
            end
        end else if (p || !r.hold_n) begin
            n.div = r.div;
        end else begin
            n.div = tick ? 4'h0 : r.div + 4'h1;
            if (tick && r.st == H_END) begin
                n.cs_n = 1'b1;
                n.st = H_IDLE;
                n.busy = 1'b0;
            end else if (tick && !r.sck) begin
                n.sck = 1'b1;
            end else if (tick) begin
                n.sck = 1'b0;
                case (r.st)
                    H_TX: begin
                        n.bc = sfp_pkg::BIT_LAST;
                        if (r.bc != 3'h0) begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.bc = r.bc - 3'h1;
                        end else if (r.hb != 2'h0) begin
                            n.sh = r.addr[23:16];
                            n.addr = {r.addr[15:0], 8'h00};
                            n.hb = r.hb - 2'h1;
                        end else if (r.wl != 9'h0) begin
                            n.sh = wdata_i;
                            n.take = 1'b1;
                            n.wl = r.wl - 9'h1;
                        end else begin
                            fin = 1'b1;
                        end
                    end
                    H_DUMMY: begin
                        if (r.dm != 4'h0) begin
                            n.dm = r.dm - 4'h1;
                        end else begin
                            fin = 1'b1;
                        end
                    end
                    H_RX: begin
                        n.sh = rs;
                        n.bc = r.bc - 3'h1;
                        if (r.bc == 3'h0) begin
                            n.rv = 1'b1;
                            n.rdat = rs;
                            n.rl = r.rl - 9'h1;
                            n.bc = sfp_pkg::lane_last(r.ln);
                            fin = r.rl == 9'h1;
                        end
                    end
                    default: n.st = r.st;
                endcase
            end
        end
        if (fin) begin
            if (r.st == H_TX && r.dm != 4'h0) begin
                n.st = H_DUMMY;
                n.dm = r.dm - 4'h1;
            end else if (r.st != H_RX && r.rl != 9'h0) begin
                n.st = H_RX;
                n.bc = sfp_pkg::lane_last(r.ln);
            end else begin
                n.st = H_END;
                n.sck = r.m3;
            end
        end
        n.io_o = {n.hold_n, wp_n_i, 1'b0, n.sh[7]};
        n.io_oe[3] = !(n.st == H_RX && n.ln == sfp_pkg::LANE4);
        n.io_oe[2] = n.io_oe[3];
        n.io_oe[1] = 1'b0;
        n.io_oe[0] = n.st == H_TX;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.cs_n <= 1'b1;
            r.hold_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign bus.cs_n = r.cs_n;
    assign bus.sck = r.sck;
    assign bus.h_io_o = r.io_o;
    assign bus.h_io_oe = r.io_oe;
    assign busy_o = r.busy;
    assign wdata_take_o = r.take;
    assign rd_valid_o = r.rv;
    assign rd_data_o = r.rdat;
endmodule

// ### verilog/sfp_device.sv
/*
 * Device end of the serial flash port: decodes command frames, keeps the
 * status bits and hands reads, page writes and erases to the array logic.
 * Assumes the array logic answers rd_addr_o within four system clocks.
 */
`timescale 1ns/1ps

// Behaviour
// - Operate only while select is low
// - Deselected: ignore input, release output lines
// - Clock modes 0 and 3 only
// - Sample on rising edge, drive on falling
// - Protect-level bits choose protected array blocks
// - Write-guard high leaves status writable
// - Quad on: write-guard pin becomes data line
// - Quad on: pause pin becomes data line
// - Pause freezes the transfer, no restart
// - Page program takes 1 to 256 bytes
// - Erase in 4K sectors, 32K, 64K blocks
// - Host clock at most 50/133 MHz
// - Single, dual and quad output reads
// - Writes need unlock; latch clears after use
// - Lock with guard low blocks status writes
// - Quad enable is a status bit
module sfp_device (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Pins
    sfp_if.dev bus,
    // Array read
    output logic [23:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    // Array write
    output logic wr_valid_o,
    output logic [23:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    // Array erase
    output logic er_valid_o,
    output sfp_pkg::sfp_erase_type er_kind_o,
    output logic [23:0] er_addr_o,
    // State
    input wire logic busy_i,
    output logic quad_enable_o,
    output logic standby_o
);
    typedef enum logic [2:0] {
        D_CMD = 3'h0, D_ADDR = 3'h1, D_DUMMY = 3'h2, D_OUT = 3'h3,
        D_PROG = 3'h4, D_WSR = 3'h5, D_SKIP = 3'h6
    } sfp_dstate_type;

    typedef struct packed {
        sfp_dstate_type st;
        logic sck_q;
        logic [7:0] sh;
        logic [2:0] bc;
        logic [7:0] cmd;
        logic [1:0] ac;
        logic [23:0] addr;
        logic [3:0] dc;
        logic [8:0] pc;
        logic [7:0] ob;
        logic [2:0] oc;
        logic osr;
        sfp_pkg::sfp_lanes_type ln;
        logic status_lock;
        logic quad_enable;
        logic [3:0] protect_level;
        logic wel;
        logic wel_used;
        logic er_pend;
        logic [3:0] io_o;
        logic [3:0] io_oe;
        logic [23:0] rd_addr;
        logic wr_v;
        logic [23:0] wr_addr;
        logic [7:0] wr_data;
        logic er_v;
        sfp_pkg::sfp_erase_type er_k;
        logic [23:0] er_addr;
    } sfp_dev_type;

    sfp_dev_type r;
    sfp_dev_type n;
    logic [5:0] pin_s;
    logic cs_s;
    logic sck_s;
    logic [3:0] io_s;
    logic rise;
    logic fall;
    logic paused;
    logic wp_n;
    logic wr_ok;
    logic [7:0] rx;
    logic [7:0] nb;
    logic [23:0] a;

    // Top 2^(level-1) of the 64K blocks are protected
    function automatic logic protected_at(input logic [23:0] ad, input logic [3:0] lvl);
        logic [8:0] cnt;
        cnt = 9'h1 << (lvl - 4'h1);
        if (lvl == 4'h0) begin
            protected_at = 1'b0;
        end else if (lvl >= sfp_pkg::PROTECT_ALL) begin
            protected_at = 1'b1;
        end else begin
            protected_at = {1'b0, ad[23:16]} >= (sfp_pkg::BLOCK_COUNT - cnt);
        end
    endfunction

    sfp_sync #(.W(6), .INIT(6'h3F)) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({bus.cs_n, bus.sck, bus.io}),
        .q_o(pin_s)
    );

    assign cs_s = pin_s[5];
    assign sck_s = pin_s[4];
    assign io_s = pin_s[3:0];
    // Edges found in either idle polarity, so modes 0 and 3 both work
    assign rise = sck_s && !r.sck_q;
    assign fall = !sck_s && r.sck_q;
    assign paused = !r.quad_enable && !io_s[3];
    assign wp_n = r.quad_enable || io_s[2];
    assign wr_ok = r.wel && !busy_i;

    always_comb begin
        rx = {r.sh[6:0], io_s[0]};
        a = {r.addr[15:0], rx};
        nb = (r.oc != 3'h0) ? r.ob :
            r.osr ? {r.status_lock, r.quad_enable, r.protect_level, r.wel, busy_i} :
            rd_data_i;
        n = r;
        n.sck_q = sck_s;
        n.wr_v = 1'b0;
        n.er_v = 1'b0;
        if (cs_s) begin
            // Deselect returns to idle and commits the pending erase
            n.st = D_CMD;
            n.bc = 3'h0;
            n.ac = 2'h0;
            n.dc = 4'h0;
            n.pc = 9'h0;
            n.oc = 3'h0;
            n.io_oe = 4'h0;
            n.er_v = r.er_pend;
            n.er_pend = 1'b0;
            n.wel = r.wel && !r.wel_used;
            n.wel_used = 1'b0;
        end else if (paused) begin
            n.sck_q = r.sck_q;
        end else if (rise) begin
            n.sh = rx;
            n.bc = r.bc + 3'h1;
            case (r.st)
                D_CMD: begin
                    if (r.bc == sfp_pkg::BIT_LAST) begin
                        n.cmd = rx;
                        n.osr = 1'b0;
                        n.ln = sfp_pkg::LANE1;
                        n.st = D_SKIP;
                        case (rx)
                            sfp_pkg::WRITE_UNLOCK_CMD: n.wel = 1'b1;
                            sfp_pkg::STATUS_READ_CMD: begin
                                n.st = D_OUT;
                                n.osr = 1'b1;
                            end
                            sfp_pkg::STATUS_WRITE_CMD: begin
                                if (wr_ok && !(r.status_lock && !wp_n)) begin
                                    n.st = D_WSR;
                                end
                            end
                            sfp_pkg::QUAD_READ_CMD: n.st = r.quad_enable ? D_ADDR : D_SKIP;
                            sfp_pkg::READ_CMD, sfp_pkg::FAST_READ_CMD,
                            sfp_pkg::DUAL_READ_CMD, sfp_pkg::PAGE_PROG_CMD,
                            sfp_pkg::ERASE_4K_CMD, sfp_pkg::ERASE_32K_CMD,
                            sfp_pkg::ERASE_64K_CMD: n.st = D_ADDR;
                            default: n.st = D_SKIP;
                        endcase
                    end
                end
                D_ADDR: begin
                    if (r.bc == sfp_pkg::BIT_LAST) begin
                        n.addr = a;
                        n.ac = r.ac + 2'h1;
                        if (r.ac == sfp_pkg::ADDR_LAST) begin
                            n.st = D_SKIP;
                            n.rd_addr = a;
                            case (r.cmd)
                                sfp_pkg::READ_CMD: n.st = D_OUT;
                                sfp_pkg::FAST_READ_CMD: n.st = D_DUMMY;
                                sfp_pkg::DUAL_READ_CMD: begin
                                    n.st = D_DUMMY;
                                    n.ln = sfp_pkg::LANE2;
                                end
                                sfp_pkg::QUAD_READ_CMD: begin
                                    n.st = D_DUMMY;
                                    n.ln = sfp_pkg::LANE4;
                                end
                                sfp_pkg::PAGE_PROG_CMD: begin
                                    if (wr_ok && !protected_at(a, r.protect_level)) begin
                                        n.st = D_PROG;
                                        n.wel_used = 1'b1;
                                    end
                                end
                                default: begin
                                    if (wr_ok && !protected_at(a, r.protect_level)) begin
                                        n.er_pend = 1'b1;
                                        n.wel_used = 1'b1;
                                        if (r.cmd == sfp_pkg::ERASE_4K_CMD) begin
                                            n.er_k = sfp_pkg::ER_4K;
                                            n.er_addr = a & sfp_pkg::SECTOR_MASK;
                                        end else if (r.cmd == sfp_pkg::ERASE_32K_CMD) begin
                                            n.er_k = sfp_pkg::ER_32K;
                                            n.er_addr = a & sfp_pkg::BLOCK32_MASK;
                                        end else begin
                                            n.er_k = sfp_pkg::ER_64K;
                                            n.er_addr = a & sfp_pkg::BLOCK64_MASK;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                end
                D_DUMMY: begin
                    n.dc = r.dc + 4'h1;
                    if (r.dc == sfp_pkg::DUMMY_LAST) begin
                        n.st = D_OUT;
                    end
                end
                D_PROG: begin
                    // Bytes past a full page are dropped
                    if (r.bc == sfp_pkg::BIT_LAST && r.pc != sfp_pkg::PAGE_BYTES) begin
                        n.wr_v = 1'b1;
                        n.wr_addr = {r.addr[23:8], r.addr[7:0] + r.pc[7:0]};
                        n.wr_data = rx;
                        n.pc = r.pc + 9'h1;
                    end
                end
                D_WSR: begin
                    if (r.bc == sfp_pkg::BIT_LAST) begin
                        n.status_lock = rx[sfp_pkg::SR_LOCK];
                        n.quad_enable = rx[sfp_pkg::SR_QE];
                        n.protect_level = rx[sfp_pkg::SR_BP_HI:sfp_pkg::SR_BP_LO];
                        n.wel_used = 1'b1;
                        n.st = D_SKIP;
                    end
                end
                default: n.st = r.st;
            endcase
        end else if (fall && r.st == D_OUT) begin
            // Next bits go out after the falling edge
            n.oc = (r.oc == 3'h0) ? sfp_pkg::lane_last(r.ln) : r.oc - 3'h1;
            if (r.oc == 3'h0 && !r.osr) begin
                n.rd_addr = r.rd_addr + 24'h1;
            end
            case (r.ln)
                sfp_pkg::LANE2: begin
                    n.io_o = {2'h0, nb[7:6]};
                    n.io_oe = 4'h3;
                    n.ob = {nb[5:0], 2'h0};
                end
                sfp_pkg::LANE4: begin
                    n.io_o = nb[7:4];
                    n.io_oe = 4'hF;
                    n.ob = {nb[3:0], 4'h0};
                end
                default: begin
                    n.io_o = {2'h0, nb[7], 1'b0};
                    n.io_oe = 4'h2;
                    n.ob = {nb[6:0], 1'b0};
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.d_io_o = r.io_o;
    assign bus.d_io_oe = r.io_oe;
    assign rd_addr_o = r.rd_addr;
    assign wr_valid_o = r.wr_v;
    assign wr_addr_o = r.wr_addr;
    assign wr_data_o = r.wr_data;
    assign er_valid_o = r.er_v;
    assign er_kind_o = r.er_k;
    assign er_addr_o = r.er_addr;
    assign quad_enable_o = r.quad_enable;
    assign standby_o = cs_s;
endmodule

// ### testbench/sfp_assertions.sv
/* Pin checker for the flash port link.
   Assumes one system clock and a host half period of 8 clocks. */
`timescale 1ns/1ps
module sfp_assertions (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Link pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] h_io_o,
    input wire logic [3:0] h_io_oe,
    input wire logic [3:0] d_io_o,
    input wire logic [3:0] d_io_oe
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Two clocks of margin over the synchroniser delay
    chk_desel_quiet: assert property (cs_n [*5] |-> d_io_oe == 4'h0)
        else $error("device drives while deselected");
    chk_select_quiet: assert property ($fell(cs_n) |-> ##4 (d_io_oe == 4'h0) [*4])
        else $error("device drives before command");
    chk_idle_level: assert property ($rose(cs_n) |-> $stable(sck))
        else $error("clock moved at deselect");
    chk_start_low: assert property ($fell(cs_n) |-> !sck)
        else $error("clock high at select");
    chk_high_half: assert property ($rose(sck) |=> $stable(sck) [*7])
        else $error("clock high half too short");
    chk_low_half: assert property ($fell(sck) && !cs_n |=> $stable(sck) [*7])
        else $error("clock low half too short");
    chk_host_shift: assert property (!cs_n && $stable({cs_n, h_io_oe[0]}) && h_io_oe[0] &&
        $changed(h_io_o[0]) |-> $fell(sck)) else $error("host data moved off falling clock");
    chk_dev_shift: assert property (d_io_oe[1] && $stable(d_io_oe[1]) &&
        $changed(d_io_o[1]) |-> !sck) else $error("device data moved in high half");
endmodule

// ### testbench/tb.sv
/* Bench joining host and device ends of the flash port.
   Assumes array reads answer at once and the array is never busy. */
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rv = 1'b0;
    logic aen = 1'b0;
    logic mode3 = 1'b0;
    logic wp_n = 1'b1;
    logic pause = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [23:0] addr = 24'h000000;
    logic [3:0] dum = 4'h0;
    logic [8:0] wl = 9'h000;
    logic [8:0] rl = 9'h000;
    sfp_pkg::sfp_lanes_type ln = sfp_pkg::LANE1;
    logic busy, take, rdv, wrv, erv, qe, standby;
    logic [7:0] rdd, wrd;
    logic [23:0] ra, wa, ea;
    sfp_pkg::sfp_erase_type ek;
    logic [7:0] rq[$];
    logic [31:0] wq[$];
    logic [25:0] eq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    sfp_if bus();
    sfp_host sfp_host_inst(.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .bus(bus), .req_valid_i(rv),
        .req_cmd_i(cmd), .req_addr_i(addr), .req_addr_en_i(aen), .req_dummy_i(dum),
        .req_wlen_i(wl), .req_rlen_i(rl), .req_lanes_i(ln), .mode3_i(mode3), .busy_o(busy),
        .wdata_i(wdata), .wdata_take_o(take), .rd_valid_o(rdv), .rd_data_o(rdd),
        .wp_n_i(wp_n), .pause_i(pause));
    sfp_device sfp_device_inst(.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .bus(bus),
        .rd_addr_o(ra), .rd_data_i(ra[7:0] ^ 8'h5A), .wr_valid_o(wrv), .wr_addr_o(wa),
        .wr_data_o(wrd), .er_valid_o(erv), .er_kind_o(ek), .er_addr_o(ea), .busy_i(1'b0),
        .quad_enable_o(qe), .standby_o(standby));
    sfp_assertions sfp_assertions_inst(.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .cs_n(bus.cs_n),
        .sck(bus.sck), .h_io_o(bus.h_io_o), .h_io_oe(bus.h_io_oe), .d_io_o(bus.d_io_o),
        .d_io_oe(bus.d_io_oe));
    always #4 sys_clk = ~sys_clk;
    task complete_run;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (rdv) rq.push_back(rdd);
        if (wrv) wq.push_back({wa, wrd});
        if (erv) eq.push_back({ek, ea});
        if (take) wdata <= wdata + 8'h11;
        if (cyc > 60000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits for the frame and the late erase pulse after deselect
    task automatic run(input logic [7:0] c, input logic [7:0] wd = 8'h10,
        input logic [8:0] w = 9'h000, input logic [23:0] a = 24'h000000,
        input logic [8:0] r = 9'h000, input logic [3:0] d = 4'h0,
        input sfp_pkg::sfp_lanes_type l = sfp_pkg::LANE1);
        int k;
        @(posedge sys_clk);
        cmd <= c;
        wdata <= wd;
        wl <= w;
        addr <= a;
        rl <= r;
        dum <= d;
        ln <= l;
        aen <= !(c inside {8'h01, 8'h05, 8'h06});
        rv <= 1'b1;
        @(posedge sys_clk);
        rv <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (k = 0; k < 9000 && busy; k++) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic st(input logic [7:0] e);
        rq.delete();
        run(8'h05, 8'h00, 9'h000, 24'h000000, 9'h001);
        chk("status", e, rq[0]);
    endtask
    task automatic wsr(input logic [7:0] v);
        run(8'h06);
        run(8'h01, v, 9'h001);
    endtask
    task automatic rd(input logic [7:0] c, input logic [23:0] a, input logic [3:0] d,
        input sfp_pkg::sfp_lanes_type l);
        rq.delete();
        run(c, 8'h00, 9'h000, a, 9'h002, d, l);
        chk("rd0", a[7:0] ^ 8'h5A, rq[0]);
        chk("rd1", (a[7:0] + 8'h01) ^ 8'h5A, rq[1]);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        st(8'h00);
        run(8'h02, 8'h10, 9'h002, 24'h000010);
        chk("unlocked_wr", 0, wq.size());
        run(8'h06);
        st(8'h02);
        run(8'h02, 8'h10, 9'h002, 24'h000010);
        chk("wr0", 32'h00001010, wq[0]);
        chk("wr1", 32'h00001121, wq[1]);
        st(8'h00);
        for (int m = 0; m < 2; m++) begin
            mode3 <= m[0];
            repeat (8) @(posedge sys_clk);
            rd(8'h03, 24'h000020, 4'h0, sfp_pkg::LANE1);
        end
        rd(8'h3B, 24'h000040, 4'h8, sfp_pkg::LANE2);
        rd(8'h0B, 24'h0000A0, 4'h8, sfp_pkg::LANE1);
        fork
            rd(8'h03, 24'h000060, 4'h0, sfp_pkg::LANE1);
            begin
                repeat (300) @(posedge sys_clk);
                pause <= 1'b1;
                repeat (100) @(posedge sys_clk);
                pause <= 1'b0;
            end
        join
        eq.delete();
        run(8'h06);
        run(8'h20, 8'h00, 9'h000, 24'h012345);
        run(8'h06);
        run(8'h52, 8'h00, 9'h000, 24'h012345);
        run(8'h06);
        run(8'hD8, 8'h00, 9'h000, 24'h012345);
        chk("er4k", 26'h0012000, eq[0]);
        chk("er32k", 26'h1010000, eq[1]);
        chk("er64k", 26'h2010000, eq[2]);
        wsr(8'h24);
        run(8'h06);
        run(8'h02, 8'h10, 9'h001, 24'h000010);
        chk("guarded_wr", 2, wq.size());
        wp_n <= 1'b0;
        wsr(8'h80);
        wsr(8'h00);
        st(8'h82);
        wp_n <= 1'b1;
        wsr(8'h00);
        st(8'h00);
        wsr(8'h40);
        chk("quad", 1, qe);
        rd(8'h6B, 24'h000080, 4'h8, sfp_pkg::LANE4);
        chk("standby", 1, standby);
        complete_run();
    end
endmodule
